//--- usb_control_address_frame_regs.sv
`timescale 1ns/100ps
module usb_control_address_frame_regs
  import usb_ctl_pkg::*;
#(
  parameter int FRAME_PERIOD = FRAME_CYCLES,
  parameter int EOP_LEN = LS_EOP_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Link engine side
  input wire logic token_active_in,
  input wire logic sof_rx_in,
  input wire logic [10:0] sof_frame_in,
  output logic module_on_out,
  output logic host_on_out,
  output logic host_logic_reset_out,
  output logic bus_reset_out,
  output logic resume_out,
  output logic ls_eop_out,
  output logic pp_even_reset_out,
  output logic sof_send_out,
  output logic [10:0] sof_frame_out,
  output logic low_speed_out,
  output logic [6:0] dev_addr_out
);
  logic [5:0] ctl_reg;
  logic [7:0] addr_reg;
  logic [10:0] frame_reg;
  logic busy_reg;
  logic host_q_reg;
  logic [31:0] rdata_next;
  logic ready_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  resume_state_e res_reg;
  logic [15:0] eop_cnt_reg;
  logic wr_ok;
  logic rd_access;
  logic addr_ok;
  logic host_mode;
  frame_if frm ();

  assign host_mode = ctl_reg[BIT_HOST_EN];
  assign addr_ok = (paddr_in == OFS_CONTROL) || (paddr_in == OFS_ADDRESS) ||
                   (paddr_in == OFS_FRAME_LOW) || (paddr_in == OFS_FRAME_HIGH);
  assign rd_access = psel_in && !penable_in && !pwrite_in;
  assign wr_ok = psel_in && penable_in && pwrite_in && ready_reg && addr_ok;

  // One wait state: setup, access, ready on second access cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (psel_in && penable_in && !ready_reg) begin
      ready_reg <= 1'b1;
      err_reg <= !addr_ok;
    end else begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr_in)
      OFS_CONTROL: begin
        rdata_next[4:0] = ctl_reg[4:0];
        rdata_next[BIT_TOKEN_BUSY] = host_mode ? busy_reg : ctl_reg[5];
      end
      OFS_ADDRESS: rdata_next[7:0] = addr_reg;
      OFS_FRAME_LOW: rdata_next[7:0] = frame_reg[7:0];
      OFS_FRAME_HIGH: rdata_next[2:0] = frame_reg[10:8];
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel_in && !ready_reg && !pwrite_in) begin
      rdata_reg <= rdata_next;
    end
  end

  // Control register; bit 5 is the packet disable latch in device mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_reg <= CONTROL_RESET[5:0];
    end else if (wr_ok && paddr_in == OFS_CONTROL) begin
      ctl_reg <= pwdata_in[5:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_reg <= ADDRESS_RESET;
    end else if (wr_ok && paddr_in == OFS_ADDRESS) begin
      addr_reg <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= token_active_in && host_mode;
    end
  end

  // Single register keeps both halves from one token
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      frame_reg <= FRAME_RESET;
    end else if (sof_rx_in && !host_mode) begin
      frame_reg <= sof_frame_in;
    end else if (frm.tick) begin
      frame_reg <= frm.count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_q_reg <= 1'b0;
      host_logic_reset_out <= 1'b0;
    end else begin
      host_q_reg <= host_mode;
      host_logic_reset_out <= host_q_reg != host_mode;
    end
  end

  // Resume: drive while set, host appends low-speed end-of-packet
  always_ff @(posedge clk_in) begin
    if (rst_in || host_logic_reset_out) begin
      res_reg <= RES_IDLE;
      eop_cnt_reg <= '0;
    end else begin
      unique case (res_reg)
        RES_IDLE: if (ctl_reg[BIT_RESUME]) res_reg <= RES_DRIVE;
        RES_DRIVE: if (!ctl_reg[BIT_RESUME]) begin
          res_reg <= host_mode ? RES_EOP : RES_IDLE;
          eop_cnt_reg <= '0;
        end
        RES_EOP: begin
          eop_cnt_reg <= eop_cnt_reg + 16'h1;
          if (eop_cnt_reg == 16'(EOP_LEN - 1)) res_reg <= RES_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      module_on_out <= 1'b0;
      host_on_out <= 1'b0;
      bus_reset_out <= 1'b0;
      resume_out <= 1'b0;
      ls_eop_out <= 1'b0;
      pp_even_reset_out <= 1'b0;
      sof_send_out <= 1'b0;
      sof_frame_out <= FRAME_RESET;
      low_speed_out <= 1'b0;
      dev_addr_out <= 7'h00;
    end else begin
      module_on_out <= !host_mode && ctl_reg[BIT_ENABLE];
      host_on_out <= host_mode;
      bus_reset_out <= host_mode && ctl_reg[BIT_BUS_RESET];
      resume_out <= ctl_reg[BIT_RESUME];
      ls_eop_out <= res_reg == RES_EOP;
      pp_even_reset_out <= ctl_reg[BIT_PP_RESET];
      sof_send_out <= frm.tick;
      sof_frame_out <= frm.count;
      low_speed_out <= addr_reg[BIT_LOW_SPEED];
      dev_addr_out <= addr_reg[6:0];
    end
  end

  assign prdata_out = rdata_reg;
  assign pready_out = ready_reg;
  assign pslverr_out = err_reg;

  frame_timer #(.PERIOD(FRAME_PERIOD)) u_frame_timer (
    .clk_in(clk_in),
    .rst_in(rst_in || host_logic_reset_out),
    .run_in(host_mode && ctl_reg[BIT_ENABLE]),
    .frm(frm)
  );

  a_bus_reset_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 bus_reset_out == $past(host_mode && ctl_reg[BIT_BUS_RESET]))
    else $error("bus reset out of step");
  a_toggle_resets_host: assert property (@(posedge clk_in) disable iff (rst_in)
    (host_mode != $past(host_mode)) |=> host_logic_reset_out)
    else $error("host toggle not reset");
  a_resume_drive: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_reg[BIT_RESUME] |=> resume_out)
    else $error("resume not driven");
  a_eop_after_resume: assert property (@(posedge clk_in) disable iff (rst_in)
    (res_reg == RES_DRIVE && !ctl_reg[BIT_RESUME] && host_mode && !host_logic_reset_out)
    |=> ##1 ls_eop_out)
    else $error("no low-speed eop");
  a_pp_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    ctl_reg[BIT_PP_RESET] |=> pp_even_reset_out)
    else $error("pointer reset missing");
  a_module_enable: assert property (@(posedge clk_in) disable iff (rst_in)
    (!host_mode && ctl_reg[BIT_ENABLE]) |=> module_on_out)
    else $error("module not enabled");
  a_no_sof_off: assert property (@(posedge clk_in) disable iff (rst_in)
    (!host_mode || !ctl_reg[BIT_ENABLE]) [*2] |=> !sof_send_out)
    else $error("sof while disabled");
  a_addr_out: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ok && paddr_in == OFS_ADDRESS |=> ##1 dev_addr_out == $past(pwdata_in[6:0], 2))
    else $error("address not applied");
  a_frame_load: assert property (@(posedge clk_in) disable iff (rst_in)
    (sof_rx_in && !host_mode) |=> frame_reg == $past(sof_frame_in))
    else $error("frame not loaded");
  a_upper_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_access |=> rdata_reg[31:8] == 24'h0)
    else $error("upper bits not zero");
  c_host_sof: cover property (@(posedge clk_in) sof_send_out);
  c_resume_eop: cover property (@(posedge clk_in) ls_eop_out);
  c_frame_rx: cover property (@(posedge clk_in) sof_rx_in && !host_mode);
  c_bad_addr: cover property (@(posedge clk_in) pslverr_out);
endmodule : usb_control_address_frame_regs

//--- usb_ctl_pkg.sv
package usb_ctl_pkg;
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_ADDRESS = 12'h004;
  localparam logic [11:0] OFS_FRAME_LOW = 12'h008;
  localparam logic [11:0] OFS_FRAME_HIGH = 12'h00C;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_PP_RESET = 1;
  localparam int BIT_RESUME = 2;
  localparam int BIT_HOST_EN = 3;
  localparam int BIT_BUS_RESET = 4;
  localparam int BIT_TOKEN_BUSY = 5;
  localparam int BIT_LOW_SPEED = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [10:0] FRAME_RESET = 11'h000;
  localparam int CLK_HZ = 50_000_000;
  localparam int FRAME_PERIOD_US = 1000;
  localparam int FRAME_CYCLES = CLK_HZ / 1_000_000 * FRAME_PERIOD_US;
  localparam int LS_EOP_NS = 1333;
  localparam int LS_EOP_CYCLES = (LS_EOP_NS + 19) / 20;
  typedef enum logic [1:0] {
    RES_IDLE,
    RES_DRIVE,
    RES_EOP
  } resume_state_e;
endpackage : usb_ctl_pkg

//--- frame_if.sv
`timescale 1ns/100ps
interface frame_if;
  logic tick;
  logic [10:0] count;
  modport source (output tick, output count);
  modport sink (input tick, input count);
endinterface : frame_if

//--- frame_timer.sv
`timescale 1ns/100ps
module frame_timer
  import usb_ctl_pkg::*;
#(
  parameter int PERIOD = FRAME_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  frame_if.source frm
);
  logic [31:0] div_reg;
  logic [10:0] cnt_reg;
  logic tick_reg;

  // Divider restarts when stopped so first frame is a full period
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == 32'(PERIOD - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= FRAME_RESET;
    end else if (tick_reg) begin
      cnt_reg <= cnt_reg + 11'h1;
    end
  end

  assign frm.tick = tick_reg;
  assign frm.count = cnt_reg;
endmodule : frame_timer

//--- usb_peer_model.sv
`timescale 1ns/100ps
module usb_peer_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bench commands
  input wire logic sof_go_in,
  input wire logic [10:0] sof_num_in,
  input wire logic busy_go_in,
  // Link engine side
  output logic token_active_out,
  output logic sof_rx_out,
  output logic [10:0] sof_frame_out
);
  // Number only valid with the pulse, so it churns otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sof_rx_out <= 1'b0;
      sof_frame_out <= 11'h000;
    end else begin
      sof_rx_out <= sof_go_in;
      sof_frame_out <= sof_go_in ? sof_num_in : ~sof_frame_out;
    end
  end
  always_ff @(posedge clk_in) begin
    token_active_out <= !rst_in && busy_go_in;
  end
endmodule : usb_peer_model

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import usb_ctl_pkg::*;
  localparam int FP = 50;
  localparam int EL = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sof_go = 1'b0;
  logic [10:0] sof_num = 11'h000;
  logic busy_go = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy, sof_rx, mod_on, host_on, host_rst, bus_rst;
  logic resume, ls_eop, pp_rst, sof_send, low_spd;
  logic [10:0] sof_frm;
  logic [10:0] sof_cnt;
  logic [6:0] dev_addr;
  int miscompares = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  usb_peer_model usb_peer_model_inst (.clk_in(clk_in), .rst_in(rst_in), .sof_go_in(sof_go),
    .sof_num_in(sof_num), .busy_go_in(busy_go), .token_active_out(busy),
    .sof_rx_out(sof_rx), .sof_frame_out(sof_frm));
  usb_control_address_frame_regs #(.FRAME_PERIOD(FP), .EOP_LEN(EL))
    usb_control_address_frame_regs_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .token_active_in(busy), .sof_rx_in(sof_rx), .sof_frame_in(sof_frm),
    .module_on_out(mod_on), .host_on_out(host_on), .host_logic_reset_out(host_rst),
    .bus_reset_out(bus_rst), .resume_out(resume), .ls_eop_out(ls_eop),
    .pp_even_reset_out(pp_rst), .sof_send_out(sof_send), .sof_frame_out(sof_cnt),
    .low_speed_out(low_spd), .dev_addr_out(dev_addr));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic expire;
    miscompares++;
    wrap_up();
  endtask : expire
  // Slave answer time comes from pready only; bounded against a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int i;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) expire();
    rd = prdata;
    check({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
    repeat (2) @(posedge clk_in);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    check(rd, exp);
  endtask : rdc
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      @(posedge clk_in);
      i++;
    end
    if (i >= lim) expire();
  endtask : wait_hi
  task automatic s_regs;
    rdc(OFS_CONTROL, 32'h0);
    rdc(OFS_ADDRESS, 32'h0);
    rdc(OFS_FRAME_LOW, 32'h0);
    rdc(OFS_FRAME_HIGH, 32'h0);
    apb(1'b1, 12'h010, 32'hFFFFFFFF, 1'b1);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    check(rd, 32'h0);
    wr(OFS_ADDRESS, 32'hFFFFFFFF);
    rdc(OFS_ADDRESS, 32'h000000FF);
    check({31'h0, low_spd}, 32'h1);
    check({25'h0, dev_addr}, 32'h7F);
    wr(OFS_ADDRESS, 32'h00000025);
    check({31'h0, low_spd}, 32'h0);
    check({25'h0, dev_addr}, 32'h25);
  endtask : s_regs
  task automatic s_device;
    wr(OFS_CONTROL, 32'h07);
    check({mod_on, pp_rst, resume, host_on}, 4'hE);
    wr(OFS_CONTROL, 32'h01);
    check({mod_on, pp_rst, resume, ls_eop}, 4'h8);
    sof_go <= 1'b1;
    sof_num <= 11'h5A3;
    @(posedge clk_in);
    sof_go <= 1'b0;
    repeat (3) @(posedge clk_in);
    wr(OFS_FRAME_LOW, 32'hFF);
    rdc(OFS_FRAME_LOW, 32'hA3);
    rdc(OFS_FRAME_HIGH, 32'h5);
    wr(OFS_CONTROL, 32'h00);
    check({31'h0, mod_on}, 32'h0);
  endtask : s_device
  task automatic s_host;
    int i;
    apb(1'b1, OFS_CONTROL, 32'h08, 1'b0);
    wait_hi(host_rst, 10);
    @(posedge clk_in);
    check({host_rst, host_on}, 2'h1);
    wr(OFS_CONTROL, 32'h18);
    check({31'h0, bus_rst}, 32'h1);
    wr(OFS_CONTROL, 32'h08);
    check({31'h0, bus_rst}, 32'h0);
    busy_go <= 1'b1;
    repeat (3) @(posedge clk_in);
    rdc(OFS_CONTROL, 32'h28);
    busy_go <= 1'b0;
    repeat (3) @(posedge clk_in);
    rdc(OFS_CONTROL, 32'h08);
    apb(1'b1, OFS_CONTROL, 32'h09, 1'b0);
    wait_hi(sof_send, FP + 10);
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (sof_send !== 1'b1 && i < FP + 10);
    check(i, FP);
    check({21'h0, sof_cnt}, 32'h1);
    wr(OFS_CONTROL, 32'h0C);
    check({31'h0, resume}, 32'h1);
    // Resume hold shortened from the wake-up time to keep the run short
    apb(1'b1, OFS_CONTROL, 32'h08, 1'b0);
    wait_hi(ls_eop, 10);
    i = 0;
    while (ls_eop === 1'b1 && i < 100) begin
      @(posedge clk_in);
      i++;
    end
    check(i, EL);
    apb(1'b1, OFS_CONTROL, 32'h00, 1'b0);
    wait_hi(host_rst, 10);
    @(posedge clk_in);
    check({31'h0, host_on}, 32'h0);
  endtask : s_host
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    s_regs();
    s_device();
    s_host();
    wrap_up();
  end
endmodule : tb_top
